// ==== src/adc_port_consts.svh ====
// offsets, field positions and reset values of the converter output port
// assumes a 4-bit byte address on the plain register port
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH
`define ADDR_CLKDIV 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_MASK 4'h8
`define ADDR_RESULT 4'hC
`define ST_LATE 0
`define ST_DONE 1
`define ST_FRAME 2
`define ST_W 3
`define CLKDIV_RST 8'h02
`define RES_BITS 5'h10
`define PIN_DIV_LO 2
`define PIN_EXT 4
`define PIN_SYNC_INV 5
`define PIN_SCLK_INV 6
`define PIN_CHAIN 7
`define PIN_SDO 8
`define PIN_SCLK 9
`define PIN_SYNC 10
`define PIN_LATE 11
`endif

// ==== src/adc_port_pkg.sv ====
// types shared by the converter output port
// assumes the constants header is included where numbers are needed
package adc_port_pkg;
   typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_e;
   typedef struct packed {
      logic serial;
      logic ext_clk;
      logic sync_inv;
      logic sclk_inv;
      logic rd_during;
      logic [1:0] div;
   } ser_cfg_s;
endpackage

// ==== src/adc_output_port.sv ====
// result output port of a 16-bit converter: parallel bus or serial port
// assumes pin inputs and conversion strobes are synchronous to mclk
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
`include "adc_port_consts.svh"
module adc_output_port (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic port_kind_select,
   input wire logic half_order_select,
   input wire logic code_format_select,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [15:0] conv_result,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe_n,
   input wire logic [3:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_we,
   input wire logic bus_re,
   output logic [31:0] bus_rdata,
   output logic irq
);
   adc_port_pkg::ser_cfg_s cfg;
   adc_port_pkg::ser_state_e state_r, state_nxt;
   logic [15:0] result_r, result_nxt;
   logic [15:0] shift_r, shift_nxt;
   logic [4:0] bit_cnt_r, bit_cnt_nxt;
   logic [10:0] div_cnt_r, div_cnt_nxt;
   // wide enough for the largest divider times eight
   logic [10:0] half_per;
   logic sclk_int_r, sclk_int_nxt;
   logic ext_prev_r;
   logic late_r, late_nxt;
   logic frame_end;
   logic load;
   logic [15:0] load_word;
   logic upd_edge;
   logic [15:0] coded;
   logic [7:0] clkdiv_r, clkdiv_nxt;
   logic [`ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt, events;
   logic [31:0] rdata_nxt;
   logic [15:0] pout_nxt, poe_nxt;
   logic irq_nxt;

   // serial role pins are read only in serial mode
   always_comb
   begin
      cfg = '0;
      if (port_kind_select)
      begin
         cfg.serial = 1'b1;
         cfg.ext_clk = pin_in[`PIN_EXT];
         cfg.sync_inv = pin_in[`PIN_SYNC_INV];
         cfg.sclk_inv = pin_in[`PIN_SCLK_INV];
         cfg.rd_during = ~pin_in[`PIN_EXT] & pin_in[`PIN_CHAIN];
         if (!pin_in[`PIN_EXT] && !pin_in[`PIN_CHAIN])
            cfg.div = pin_in[`PIN_DIV_LO+1:`PIN_DIV_LO];
      end
   end

   assign coded = {conv_result[15] ^ ~code_format_select,
                   conv_result[14:0]};

   // a zero divider would stall the clock, so it counts as one
   always_comb
   begin
      half_per = {3'b000, (clkdiv_r == 8'h00) ? 8'h01 : clkdiv_r};
      half_per = half_per << cfg.div;
   end

   // host clock edge that updates data, from the sampled pin level
   assign upd_edge = cfg.ext_clk &
      ((pin_in[`PIN_SCLK] ^ cfg.sclk_inv) &
       ~(ext_prev_r ^ cfg.sclk_inv));

   // read during conversion ships the previous result at conversion start
   always_comb
   begin
      load = 1'b0;
      load_word = coded;
      if (cfg.serial)
      begin
         if (!cfg.ext_clk && cfg.rd_during)
         begin
            load = conv_start;
            load_word = result_r;
         end
         else
            load = conv_done;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bit_cnt_nxt = bit_cnt_r;
      div_cnt_nxt = div_cnt_r;
      sclk_int_nxt = sclk_int_r;
      late_nxt = 1'b0;
      frame_end = 1'b0;
      result_nxt = conv_done ? coded : result_r;
      unique case (state_r)
         adc_port_pkg::SER_IDLE:
         begin
            sclk_int_nxt = 1'b0;
            div_cnt_nxt = '0;
         end
         adc_port_pkg::SER_SHIFT:
         begin
            if (!cfg.serial)
               state_nxt = adc_port_pkg::SER_IDLE;
            else if (cfg.ext_clk)
            begin
               if (upd_edge)
               begin
                  // chain input follows the result out of the far end
                  shift_nxt = {shift_r[14:0], pin_in[`PIN_CHAIN]};
                  if (bit_cnt_r != `RES_BITS)
                     bit_cnt_nxt = bit_cnt_r + 5'h01;
                  frame_end = (bit_cnt_r == `RES_BITS - 5'h01);
               end
            end
            else if (div_cnt_r >= half_per - 11'h001)
            begin
               div_cnt_nxt = '0;
               sclk_int_nxt = ~sclk_int_r;
               if (sclk_int_r)
               begin
                  shift_nxt = {shift_r[14:0], 1'b0};
                  bit_cnt_nxt = bit_cnt_r + 5'h01;
                  if (bit_cnt_r == `RES_BITS - 5'h01)
                  begin
                     frame_end = 1'b1;
                     state_nxt = adc_port_pkg::SER_IDLE;
                  end
               end
            end
            else
               div_cnt_nxt = div_cnt_r + 11'h001;
         end
      endcase
      if (load)
      begin
         // slave read cut short by the next result: old word dropped
         if (cfg.ext_clk && state_r == adc_port_pkg::SER_SHIFT &&
             bit_cnt_r != 5'h00 && bit_cnt_r != `RES_BITS)
            late_nxt = 1'b1;
         state_nxt = adc_port_pkg::SER_SHIFT;
         shift_nxt = load_word;
         bit_cnt_nxt = '0;
         div_cnt_nxt = '0;
         sclk_int_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= adc_port_pkg::SER_IDLE;
         result_r <= 16'h0000;
         shift_r <= 16'h0000;
         bit_cnt_r <= 5'h00;
         div_cnt_r <= 11'h000;
         sclk_int_r <= 1'b0;
         ext_prev_r <= 1'b0;
         late_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         result_r <= result_nxt;
         shift_r <= shift_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         div_cnt_r <= div_cnt_nxt;
         sclk_int_r <= sclk_int_nxt;
         ext_prev_r <= pin_in[`PIN_SCLK];
         late_r <= late_nxt;
      end
   end

   // pin drive: one cycle behind the engine, equal for clock and data
   always_comb
   begin
      pout_nxt = half_order_select ? {result_r[7:0], result_r[15:8]}
                                   : result_r;
      poe_nxt = 16'h0000;
      if (cfg.serial)
      begin
         poe_nxt[7:0] = 8'hFF;
         pout_nxt[7:0] = 8'h00;
         pout_nxt[`PIN_SDO] = shift_r[15];
         pout_nxt[`PIN_SYNC] = cfg.sync_inv ^
            ((state_r == adc_port_pkg::SER_SHIFT) &&
             (bit_cnt_r != `RES_BITS));
         pout_nxt[`PIN_LATE] = late_r & cfg.ext_clk;
         poe_nxt[`PIN_SCLK] = cfg.ext_clk;
         pout_nxt[`PIN_SCLK] = cfg.ext_clk ? 1'b0
            : (sclk_int_r ^ cfg.sclk_inv);
      end
   end

   // sticky events, set beats a same-cycle clear
   always_comb
   begin
      events = '0;
      events[`ST_LATE] = late_r;
      events[`ST_DONE] = conv_done;
      events[`ST_FRAME] = frame_end;
      clkdiv_nxt = clkdiv_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      if (bus_we && bus_addr == `ADDR_CLKDIV)
         clkdiv_nxt = bus_wdata[7:0];
      if (bus_we && bus_addr == `ADDR_MASK)
         mask_nxt = bus_wdata[`ST_W-1:0];
      if (bus_we && bus_addr == `ADDR_STATUS)
         status_nxt = status_r & ~bus_wdata[`ST_W-1:0];
      status_nxt = status_nxt | events;
      irq_nxt = |(status_nxt & mask_nxt);
      rdata_nxt = 32'h0000_0000;
      if (bus_re)
      begin
         unique case (bus_addr)
            `ADDR_CLKDIV: rdata_nxt = {24'h000000, clkdiv_r};
            `ADDR_STATUS: rdata_nxt = {29'h0000_0000, status_r};
            `ADDR_MASK: rdata_nxt = {29'h0000_0000, mask_r};
            `ADDR_RESULT: rdata_nxt = {16'h0000, result_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clkdiv_r <= `CLKDIV_RST;
         mask_r <= '0;
         status_r <= '0;
         irq <= 1'b0;
         bus_rdata <= 32'h0000_0000;
         pin_out <= 16'h0000;
         pin_oe_n <= 16'hFFFF;
      end
      else
      begin
         clkdiv_r <= clkdiv_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         irq <= irq_nxt;
         bus_rdata <= rdata_nxt;
         pin_out <= pout_nxt;
         pin_oe_n <= poe_nxt;
      end
   end

   byte_order_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      !port_kind_select |=> pin_out[7:0] == ($past(half_order_select)
         ? $past(result_r[15:8]) : $past(result_r[7:0])))
      else $error("parallel byte order wrong");

   code_format_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      conv_done |=> result_r[15] ==
         ($past(conv_result[15]) ^ ~$past(code_format_select)))
      else $error("msb coding wrong");

   serial_float_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      port_kind_select |=> pin_oe_n[1:0] == 2'b11)
      else $error("low data pins driven in serial mode");

   parallel_drive_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      !port_kind_select |=> pin_oe_n == 16'h0000)
      else $error("parallel pins not all driven");

   sync_idle_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      (cfg.serial && state_r == adc_port_pkg::SER_IDLE) |=>
         pin_out[`PIN_SYNC] == $past(cfg.sync_inv))
      else $error("frame marker not at idle level");

   late_read_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      (cfg.ext_clk && load && state_r == adc_port_pkg::SER_SHIFT &&
       bit_cnt_r inside {[5'h01:5'h0F]}) |=> late_r ##1 !late_r)
      else $error("late read not pulsed");

   chain_shift_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      (upd_edge && !load && state_r == adc_port_pkg::SER_SHIFT) |=>
         shift_r[0] == $past(pin_in[`PIN_CHAIN]))
      else $error("chain bit not shifted in");

   msb_load_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      load |=> shift_r == $past(load_word) ##1 pin_out[`PIN_SDO] == shift_r[15]
         || $past(upd_edge))
      else $error("result not loaded msb first");

   master_clk_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      (cfg.serial && !cfg.ext_clk) |=> !pin_oe_n[`PIN_SCLK])
      else $error("internal clock not driven out");

   sticky_set_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      late_r |=> status_r[`ST_LATE])
      else $error("late event lost in status");
endmodule

// ==== verif/host_link_model.sv ====
// host end of the serial port: clock source, chain source, bit collector
// assumes pin_out is settled by the falling mclk edge
`timescale 1ns/1ns
module host_link_model (
   input wire logic mclk,
   input wire logic [15:0] pin_out,
   input wire logic mark_lvl,
   output logic host_sclk,
   output logic chain_bit
);
   logic [31:0] got_bits = 32'h0;
   logic [31:0] mid_bits = 32'h0;
   logic prev_sclk = 1'h0;
   int toggles = 0;
   initial host_sclk = 1'h0;
   initial chain_bit = 1'h1;
   // master: odd toggles fall mid-bit, whatever the clock sense
   always @(negedge mclk)
   begin
      if (pin_out[10] === mark_lvl && pin_out[9] !== prev_sclk)
      begin
         toggles++;
         if (toggles[0])
            got_bits = {got_bits[30:0], pin_out[8]};
      end
      prev_sclk = pin_out[9];
   end
   // slave: clock idle between frames; bit taken before update
   // and again before the return edge, where a wrong sense shows
   task automatic slave_read(input int n, input logic inv);
      host_sclk <= inv;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < n; i++)
      begin
         @(negedge mclk) got_bits = {got_bits[30:0], pin_out[8]};
         @(posedge mclk);
         host_sclk <= ~inv;
         chain_bit <= i[0];
         repeat (2) @(posedge mclk);
         @(negedge mclk) mid_bits = {mid_bits[30:0], pin_out[8]};
         @(posedge mclk) host_sclk <= inv;
         repeat (3) @(posedge mclk);
      end
   endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the converter result port
// assumes design and host model are compiled first
`timescale 1ns/1ns
module testbench;
   logic mclk = 1'h0;
   logic sys_rst = 1'h1;
   logic half_order_select = 1'h0;
   logic code_format_select = 1'h1;
   logic conv_start = 1'h0;
   logic conv_done = 1'h0;
   logic [15:0] conv_result = 16'h0;
   logic [3:0] bus_addr = 4'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_we = 1'h0;
   logic bus_re = 1'h0;
   adc_port_pkg::ser_cfg_s cfg = '0;
   logic [15:0] pin_in, pin_out, pin_oe_n;
   logic [31:0] bus_rdata, rd;
   logic irq, host_sclk, chain_bit;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int n;
   assign pin_in = {6'h00, host_sclk, 1'h0,
      cfg.ext_clk ? chain_bit : cfg.rd_during, cfg.sclk_inv, cfg.sync_inv,
      cfg.ext_clk, cfg.div, 2'h0};
   adc_output_port DUT (.mclk(mclk), .sys_rst(sys_rst),
      .port_kind_select(cfg.serial), .half_order_select(half_order_select),
      .code_format_select(code_format_select), .conv_start(conv_start),
      .conv_done(conv_done), .conv_result(conv_result), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
      .bus_rdata(bus_rdata), .irq(irq));
   host_link_model u_host (.mclk(mclk), .pin_out(pin_out),
      .mark_lvl(~cfg.sync_inv), .host_sclk(host_sclk), .chain_bit(chain_bit));
   initial
   begin
      forever #5 mclk = ~mclk;
   end
   // whole run is under two thousand cycles; a hang ends here
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk) {bus_we, bus_addr, bus_wdata} <= {1'h1, a, d};
      @(posedge mclk) bus_we <= 1'h0;
   endtask
   task automatic read_expect(input logic [3:0] a, input logic [31:0] e);
      @(posedge mclk) {bus_re, bus_addr} <= {1'h1, a};
      @(posedge mclk) bus_re <= 1'h0;
      @(negedge mclk) rd = bus_rdata;
      check(rd, e);
   endtask
   task automatic convert(input logic [15:0] r, input logic at_start);
      @(posedge mclk)
      begin
         conv_result <= r;
         conv_done <= ~at_start;
         conv_start <= at_start;
      end
      @(posedge mclk) {conv_done, conv_start} <= 2'h0;
   endtask
   // serial pins set to odd values: parallel mode must not care
   task automatic t_parallel();
      @(posedge mclk) cfg <= 7'h3F;
      convert(16'h12F4, 1'h0);
      settle(3);
      check(pin_out, 16'h12F4);
      check(pin_oe_n, 16'h0000);
      @(posedge mclk) {half_order_select, code_format_select} <= 2'h2;
      convert(16'h12F4, 1'h0);
      settle(3);
      check(pin_out, 16'hF492);
      read_expect(4'hC, 32'h92F4);
      @(posedge mclk) half_order_select <= 1'h0;
   endtask
   task automatic t_master(input logic [6:0] c, input logic cf,
      input logic [15:0] r, input logic at_start, input logic [15:0] e,
      input int half);
      @(posedge mclk)
      begin
         cfg <= c;
         code_format_select <= cf;
      end
      u_host.toggles = 0;
      convert(r, at_start);
      n = 0;
      repeat (300)
      begin
         @(negedge mclk);
         if (pin_out[10] !== cfg.sync_inv)
            n++;
      end
      check(32'((n + 2) / (2 * half)), 32'h10);
      check(u_host.got_bits[15:0], e);
      check(pin_oe_n, 16'h00FF);
      check(pin_out[9], c[3]);
      read_expect(4'h4, {29'h0, 1'h1, ~at_start, 1'h0});
   endtask
   task automatic t_slave(input logic inv);
      @(posedge mclk) cfg <= {3'h7, inv, 3'h0};
      code_format_select <= 1'h1;
      u_host.slave_read(0, inv);
      convert(16'h5A3C, 1'h0);
      u_host.slave_read(20, inv);
      check(u_host.got_bits[19:0], 20'h5A3C5);
      check(u_host.mid_bits[19:0], 20'hB478A);
      check(pin_oe_n, 16'h02FF);
      check(pin_out[9], 1'h0);
      bus_write(4'h4, 32'h7);
   endtask
   task automatic t_late();
      bus_write(4'h8, 32'h1);
      convert(16'h1234, 1'h0);
      u_host.slave_read(5, cfg.sclk_inv);
      convert(16'h4321, 1'h0);
      n = 0;
      repeat (4)
      begin
         @(negedge mclk);
         if (pin_out[11] === 1'h1)
            n++;
      end
      check(n, 1);
      check(irq, 1'h1);
      bus_write(4'h8, 32'h0);
      settle(2);
      check(irq, 1'h0);
      bus_write(4'h4, 32'h7);
      bus_write(4'h8, 32'h1);
      settle(2);
      check(irq, 1'h0);
      read_expect(4'h4, 32'h0);
   endtask
   initial
   begin
      repeat (15) @(posedge mclk);
      @(negedge mclk) check(pin_oe_n, 16'hFFFF);
      @(posedge mclk) sys_rst <= 1'h0;
      read_expect(4'h0, 32'h2);
      read_expect(4'h8, 32'h0);
      read_expect(4'h2, 32'h0);
      bus_write(4'h8, 32'h4);
      t_parallel();
      bus_write(4'h4, 32'h7);
      rd = 32'h0;
      t_master(7'h40, 1'h0, 16'hC35A, 1'h0, 16'h435A, 2);
      settle(2);
      check(irq, 1'h1);
      bus_write(4'h4, 32'h7);
      rd = 32'h0;
      t_master(7'h59, 1'h1, 16'h6A0F, 1'h0, 16'h6A0F, 4);
      bus_write(4'h4, 32'h7);
      rd = 32'h0;
      t_master(7'h47, 1'h1, 16'h0000, 1'h1, 16'h6A0F, 2);
      bus_write(4'h4, 32'h7);
      t_slave(1'h0);
      t_slave(1'h1);
      t_late();
      complete_run();
   end
endmodule
